// *** inc/tsr_pkg.sv ***
// Purpose: shared constants for the temperature sensor register and alert block
// Assumes: 125 MHz core clock, 8-bit command and data bytes
// Notes: raw converter words are signed quarter degrees
package tsr_pkg;

	// clock and timing
	localparam int CLK_HZ = 125_000_000;
	localparam int CONV_TIME_MS = 125;
	localparam int RATE_STEP_MS = 125;
	localparam int CONV_CYCLES_DFLT = (CLK_HZ / 1000) * CONV_TIME_MS;
	localparam int STEP_CYCLES_DFLT = (CLK_HZ / 1000) * RATE_STEP_MS;
	localparam int STRAP_WAIT = 2;

	// command codes
	localparam logic [7:0] CMD_RD_LOCAL = 8'h00;
	localparam logic [7:0] CMD_RD_REMOTE = 8'h01;
	localparam logic [7:0] CMD_RD_STATUS = 8'h02;
	localparam logic [7:0] CMD_RD_CONFIG = 8'h03;
	localparam logic [7:0] CMD_RD_RATE = 8'h04;
	localparam logic [7:0] CMD_RD_LHIGH = 8'h05;
	localparam logic [7:0] CMD_RD_LLOW = 8'h06;
	localparam logic [7:0] CMD_RD_RHIGH = 8'h07;
	localparam logic [7:0] CMD_RD_RLOW = 8'h08;
	localparam logic [7:0] CMD_WR_CONFIG = 8'h09;
	localparam logic [7:0] CMD_WR_RATE = 8'h0a;
	localparam logic [7:0] CMD_WR_LHIGH = 8'h0b;
	localparam logic [7:0] CMD_WR_LLOW = 8'h0c;
	localparam logic [7:0] CMD_WR_RHIGH = 8'h0d;
	localparam logic [7:0] CMD_WR_RLOW = 8'h0e;
	localparam logic [7:0] CMD_ONESHOT = 8'h0f;
	localparam logic [7:0] CMD_SW_RESET = 8'hfc;
	localparam logic [7:0] CMD_RD_MAKER = 8'hfe;
	localparam logic [7:0] CMD_RD_PART = 8'hff;
	localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;

	// reset values and temperature codes
	localparam logic [7:0] PTR_RST = 8'h00;
	localparam logic [7:0] TEMP_RST = 8'h00;
	localparam logic [7:0] RATE_RST = 8'h00;
	localparam logic [7:0] HIGH_LIM_RST = 8'h7f;
	localparam logic [7:0] LOW_LIM_RST = 8'hc9;
	localparam logic [7:0] TEMP_MAX = 8'h7f;
	localparam logic [7:0] TEMP_MIN = 8'hbf;
	localparam logic [7:0] TEMP_ZERO = 8'h00;
	localparam int TEMP_HI_INT = 127;
	localparam int TEMP_LO_INT = -65;

	// config and status fields
	localparam int CFG_MASK_BIT = 7;
	localparam int CFG_STOP_BIT = 6;
	localparam logic [5:0] CFG_LOW_READ = 6'h0f;
	localparam logic [1:0] STAT_LOW_READ = 2'h0;
	localparam int RATE_SEL_W = 3;
	localparam logic [7:0] RATE_SLOWEST = 8'h80;

	// converter word format
	localparam int RAW_W = 12;
	localparam int FRAC_W = 2;
	localparam logic [RAW_W:0] RAW_HALF = 13'h0002;

	// positions in the synchronised input vector
	localparam int SY_SCL = 0;
	localparam int SY_SDA = 1;
	localparam int SY_STANDBY_N = 2;
	localparam int SY_OPEN = 3;
	localparam int SY_SHORT_LO = 4;
	localparam int SY_SHORT_HI = 5;
	localparam int SY_STRAP = 6;
	localparam int SY_LOCAL = 13;
	localparam int SY_REMOTE = 25;
	localparam int SY_W = 37;

	// serial slave states
	typedef enum logic [2:0] {S_IDLE, S_ADDR, S_CMD, S_WDAT, S_ACK, S_RDAT, S_RACK, S_IGNORE} tsr_state_t;

endpackage

// *** rtl/tsr_sync.sv ***
// Purpose: two-stage synchroniser with edge flags for pin inputs
// Assumes: inputs are asynchronous to CLK_I
// Notes: edges are taken from the second stage only
`timescale 1ns/1ns
module tsr_sync #(
	parameter int W = 1
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// pins in
	input wire logic [W-1:0] async_i,
	// synchronised level and edges
	output logic [W-1:0] level_o,
	output logic [W-1:0] rise_o,
	output logic [W-1:0] fall_o
);
	genvar g;

	generate
		for (g = 0; g < W; g++)
		begin : g_bit
			logic meta;
			logic stable;
			logic prev;
			// meta feeds only stable, never any gate
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					meta <= 1'b0;
					stable <= 1'b0;
					prev <= 1'b0;
				end
				else
				begin
					meta <= async_i[g];
					stable <= meta;
					prev <= stable;
				end
			end
			assign level_o[g] = stable;
			assign rise_o[g] = stable & ~prev;
			assign fall_o[g] = ~stable & prev;
		end
	endgenerate

endmodule // tsr_sync

// *** rtl/tsr_top.sv ***
// Purpose: registers, conversion sequencing and latched alert of a two-channel temperature sensor
// Assumes: serial bus pins oversampled by CLK_I; converter results ready as signed quarter degrees
// Notes: pins pass through tsr_sync before use
// Contract
// - results are 8-bit signed whole degrees, clamped to +127 and -65
// - four limits per channel pair; reaching or passing a limit raises alert
// - high limits reset to 7f, low limits reset to c9
// - open-diode detector is sampled at each conversion start into status
// - no diode fault is reported before the first conversion starts
// - remote shorted low reads zero
// - remote shorted to supply reads +127 on both channels and alarms
// - alert is latched and cleared only by a good alert response read, a hardware reset or a software reset
// - limit hits on both channels and open diode set the alert latch
// - alert does not stop automatic conversions or register reads
// - alert can be raised at most once per conversion
// - host reads alert response address; alerting devices reply with their address
// - alert reply byte is own strapped address then a one bit
// - lost arbitration gives up the bus, keeps alert low
// - command byte selects register, one-shot, software reset or identity
// - command pointer resets to zero so plain reads return local temperature
// - temperature registers reset to zero and stay so in hardware standby
// - one-shot in software standby converts once then stays in standby
// - one-shot during a running conversion is ignored
// - one-shot between automatic conversions starts one and restarts the rate timer
// - config reads back with low six bits forced to 001111
// - config bit 7 masks all alert assertions
// - config bit 6 halts conversion at once and holds standby
`timescale 1ns/1ns
module tsr_top
	import tsr_pkg::*;
#(
	parameter int CONV_CYCLES = CONV_CYCLES_DFLT,
	parameter int STEP_CYCLES = STEP_CYCLES_DFLT,
	parameter logic [7:0] MAKER_ID = 8'h5a, // value is arbitrary
	parameter logic [7:0] PART_ID = 8'h3c // value is arbitrary
)
(
	// clock and reset
	input wire logic CLK_I,
	input wire logic RESET_I,
	// serial bus pins
	input wire logic SMB_CLK_I,
	input wire logic SMB_DATA_I,
	output logic SMB_DATA_O,
	output logic SMB_DATA_OE_N_O,
	// open-drain alert pin
	output logic ALERT_O,
	output logic ALERT_OE_N_O,
	// straps and standby pin
	input wire logic [6:0] ADDR_STRAP_I,
	input wire logic HARDWARE_STANDBY_PIN_N_I,
	// converter front end
	input wire logic [RAW_W-1:0] LOCAL_RAW_I,
	input wire logic [RAW_W-1:0] REMOTE_RAW_I,
	input wire logic REMOTE_DIODE_OPEN_I,
	input wire logic REMOTE_SHORT_LOW_I,
	input wire logic REMOTE_SHORT_SUPPLY_I
);
	localparam int CW = $clog2(CONV_CYCLES + 1);
	localparam int SW = $clog2(STEP_CYCLES + 1);

	logic [SY_W-1:0] syn_raw;
	logic [SY_W-1:0] syn;
	logic [SY_W-1:0] syn_rise;
	logic [SY_W-1:0] syn_fall;
	logic scl, sda, scl_rise, scl_fall, start_cond, stop_cond;
	logic standby_n, open_s, short_lo, short_hi;
	logic soft_por, rst, pin_low;
	logic [1:0] strap_cnt;
	logic [6:0] own_addr;
	tsr_state_t state, ack_next;
	logic [2:0] bit_cnt;
	logic [7:0] rx, tx, byte_in, rd_byte, reg_rd, pointer;
	logic oe_n, ack_phase, ara, last_rise, addr_hit, lost;
	logic cmd_take, data_take, tx_done;
	logic [1:0] cfg;
	logic [7:0] rate, loc_temp, rem_temp, loc_high, loc_low, rem_high, rem_low;
	logic [4:0] flags, flag_set, flag_clr;
	logic [3:0] hits;
	logic alert_n, alert_set, alert_clr;
	logic busy, due, open_seen, auto_mode, abort, os_start, conv_start, conv_done, step_tick;
	logic [CW-1:0] conv_cnt;
	logic [SW-1:0] step_cnt;
	logic [7:0] units, interval;
	logic [7:0] loc_new, rem_new;

	// round half up to whole degrees and clamp
	function automatic logic [7:0] to_deg(input logic [RAW_W-1:0] raw);
		logic [RAW_W:0] sum;
		logic signed [RAW_W-FRAC_W:0] deg;
		sum = {raw[RAW_W-1], raw} + RAW_HALF;
		deg = $signed(sum[RAW_W:FRAC_W]);
		if (int'(deg) > TEMP_HI_INT)
			return TEMP_MAX;
		else if (int'(deg) < TEMP_LO_INT)
			return TEMP_MIN;
		else
			return deg[7:0];
	endfunction

	// every pin is synchronised before use
	assign syn_raw = {REMOTE_RAW_I, LOCAL_RAW_I, ADDR_STRAP_I, REMOTE_SHORT_SUPPLY_I, REMOTE_SHORT_LOW_I,
		REMOTE_DIODE_OPEN_I, HARDWARE_STANDBY_PIN_N_I, SMB_DATA_I, SMB_CLK_I};

	tsr_sync #(
		.W(SY_W)
	) u_sync (
		.clk_i(CLK_I),
		.rst_i(RESET_I),
		.async_i(syn_raw),
		.level_o(syn),
		.rise_o(syn_rise),
		.fall_o(syn_fall)
	);

	// decoded pin levels and bus conditions
	assign scl = syn[SY_SCL];
	assign sda = syn[SY_SDA];
	assign scl_rise = syn_rise[SY_SCL];
	assign scl_fall = syn_fall[SY_SCL];
	assign start_cond = scl & syn_fall[SY_SDA];
	assign stop_cond = scl & syn_rise[SY_SDA];
	assign standby_n = syn[SY_STANDBY_N];
	assign open_s = syn[SY_OPEN];
	assign short_lo = syn[SY_SHORT_LO];
	assign short_hi = syn[SY_SHORT_HI];

	// software reset restores register state, not the bus engine
	assign rst = RESET_I | soft_por;

	always_ff @(posedge CLK_I)
	begin
		if (RESET_I)
			soft_por <= 1'b0;
		else
			soft_por <= cmd_take && (byte_in == CMD_SW_RESET);
	end

	// pins only ever pull low
	always_ff @(posedge CLK_I)
	begin
		pin_low <= 1'b0;
	end
	assign SMB_DATA_O = pin_low;
	assign ALERT_O = pin_low;
	assign SMB_DATA_OE_N_O = oe_n;
	assign ALERT_OE_N_O = alert_n;

	// strap is caught after release, once the synchroniser has settled
	always_ff @(posedge CLK_I)
	begin
		if (RESET_I)
		begin
			strap_cnt <= 2'h0;
			own_addr <= 7'h00;
		end
		else if (strap_cnt != 2'(STRAP_WAIT + 1))
		begin
			strap_cnt <= strap_cnt + 2'h1;
			if (strap_cnt == 2'(STRAP_WAIT))
				own_addr <= syn[SY_STRAP +: 7];
		end
	end

	// byte-level decode of the serial engine
	assign byte_in = {rx[6:0], sda};
	assign last_rise = scl_rise && (bit_cnt == 3'h7);
	// answer alert response only while pending
	assign addr_hit = (byte_in[7:1] == own_addr) || ((byte_in[7:1] == ALERT_RESP_ADDR) && byte_in[0] && !alert_n);
	// released one read back low loses
	assign lost = ara && tx[7] && !sda;
	assign cmd_take = (state == S_CMD) && last_rise;
	assign data_take = (state == S_WDAT) && last_rise;
	assign tx_done = (state == S_RDAT) && last_rise && !lost;
	// reply is own address with a one
	assign rd_byte = ara ? {own_addr, 1'b1} : reg_rd;

	// serial slave engine, sampling on clock rise and driving after fall
	always_ff @(posedge CLK_I)
	begin
		if (RESET_I)
		begin
			state <= S_IDLE;
			ack_next <= S_IDLE;
			bit_cnt <= 3'h0;
			rx <= 8'h00;
			tx <= 8'h00;
			oe_n <= 1'b1;
			ack_phase <= 1'b0;
			ara <= 1'b0;
		end
		else if (stop_cond)
		begin
			state <= S_IDLE;
			oe_n <= 1'b1;
		end
		else if (start_cond)
		begin
			state <= S_ADDR;
			bit_cnt <= 3'h0;
			oe_n <= 1'b1;
			ack_phase <= 1'b0;
		end
		else
		begin
			unique case (state)
				S_IDLE, S_IGNORE:
				begin
				end
				S_ADDR, S_CMD, S_WDAT:
				if (scl_rise)
				begin
					rx <= byte_in;
					bit_cnt <= bit_cnt + 3'h1;
					if (last_rise)
					begin
						state <= S_ACK;
						ack_next <= S_WDAT;
						if (state == S_ADDR)
						begin
							ara <= byte_in[7:1] == ALERT_RESP_ADDR;
							ack_next <= byte_in[0] ? S_RDAT : S_CMD;
							if (!addr_hit)
								state <= S_IGNORE;
						end
					end
				end
				S_ACK:
				if (scl_fall)
				begin
					ack_phase <= !ack_phase;
					oe_n <= ack_phase;
					if (ack_phase)
					begin
						state <= ack_next;
						bit_cnt <= 3'h0;
						if (ack_next == S_RDAT)
						begin
							tx <= rd_byte;
							oe_n <= rd_byte[7];
						end
					end
				end
				S_RDAT:
				if (scl_rise)
				begin
					if (lost)
					begin
						state <= S_IGNORE;
						oe_n <= 1'b1;
					end
					else
					begin
						bit_cnt <= bit_cnt + 3'h1;
						if (last_rise)
						begin
							state <= S_RACK;
							ack_phase <= 1'b0;
						end
					end
				end
				else if (scl_fall)
				begin
					tx <= {tx[6:0], 1'b0};
					oe_n <= tx[6];
				end
				S_RACK:
				if (scl_fall && !ack_phase)
				begin
					oe_n <= 1'b1;
					ack_phase <= 1'b1;
				end
				else if (scl_rise && ack_phase && sda)
					state <= S_IGNORE; // master nack ends the read
				else if (scl_fall && ack_phase)
				begin
					state <= S_RDAT;
					ack_phase <= 1'b0;
					bit_cnt <= 3'h0;
					tx <= rd_byte;
					oe_n <= rd_byte[7];
				end
			endcase
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (rst)
			pointer <= PTR_RST;
		else if (cmd_take)
			pointer <= byte_in;
	end

	always_ff @(posedge CLK_I)
	begin
		if (rst)
		begin
			cfg <= 2'h0;
			rate <= RATE_RST;
			loc_high <= HIGH_LIM_RST;
			loc_low <= LOW_LIM_RST;
			rem_high <= HIGH_LIM_RST;
			rem_low <= LOW_LIM_RST;
		end
		else if (data_take)
		begin
			unique case (pointer)
				CMD_WR_CONFIG: cfg <= byte_in[CFG_MASK_BIT:CFG_STOP_BIT];
				CMD_WR_RATE: rate <= byte_in;
				CMD_WR_LHIGH: loc_high <= byte_in;
				CMD_WR_LLOW: loc_low <= byte_in;
				CMD_WR_RHIGH: rem_high <= byte_in;
				CMD_WR_RLOW: rem_low <= byte_in;
				default:
				begin
				end
			endcase
		end
	end

	// read mux, unknown codes read zero
	always_comb
	begin
		unique case (pointer)
			CMD_RD_LOCAL: reg_rd = loc_temp;
			CMD_RD_REMOTE: reg_rd = rem_temp;
			CMD_RD_STATUS: reg_rd = {busy, flags, STAT_LOW_READ};
			CMD_RD_CONFIG: reg_rd = {cfg, CFG_LOW_READ};
			CMD_RD_RATE: reg_rd = rate;
			CMD_RD_LHIGH: reg_rd = loc_high;
			CMD_RD_LLOW: reg_rd = loc_low;
			CMD_RD_RHIGH: reg_rd = rem_high;
			CMD_RD_RLOW: reg_rd = rem_low;
			CMD_RD_MAKER: reg_rd = MAKER_ID;
			CMD_RD_PART: reg_rd = PART_ID;
			default: reg_rd = 8'h00;
		endcase
	end

	// stop bit or standby pin halts conversion
	assign auto_mode = !cfg[CFG_STOP_BIT - CFG_STOP_BIT] && standby_n;
	assign abort = !standby_n || (data_take && (pointer == CMD_WR_CONFIG) && byte_in[CFG_STOP_BIT]);
	assign os_start = cmd_take && (byte_in == CMD_ONESHOT) && !busy && standby_n;
	// alert plays no part in starting
	assign conv_start = (os_start || (auto_mode && due && !busy)) && !abort;
	assign conv_done = busy && (conv_cnt == CW'(CONV_CYCLES - 1)) && !abort;

	// one-shot runs once, standby holds afterwards
	always_ff @(posedge CLK_I)
	begin
		if (rst)
		begin
			busy <= 1'b0;
			conv_cnt <= '0;
		end
		else if (abort || conv_done)
			busy <= 1'b0;
		else if (conv_start)
		begin
			busy <= 1'b1;
			conv_cnt <= '0;
		end
		else if (busy)
			conv_cnt <= conv_cnt + CW'(1);
	end

	// rate timer in eighth-second steps, keeps the long count narrow
	assign step_tick = step_cnt == SW'(STEP_CYCLES - 1);
	assign interval = RATE_SLOWEST >> rate[RATE_SEL_W-1:0];

	// any start restarts the rate timer
	always_ff @(posedge CLK_I)
	begin
		if (rst)
		begin
			step_cnt <= '0;
			units <= 8'h00;
			due <= 1'b1;
		end
		else if (conv_start || !auto_mode)
		begin
			step_cnt <= '0;
			units <= 8'h00;
			due <= !auto_mode;
		end
		else if (step_tick)
		begin
			step_cnt <= '0;
			units <= units + 8'h01;
			if (units == interval - 8'h01)
				due <= 1'b1;
		end
		else
			step_cnt <= step_cnt + SW'(1);
	end

	always_comb
	begin
		loc_new = short_hi ? TEMP_MAX : to_deg(syn[SY_LOCAL +: RAW_W]);
		rem_new = short_hi ? TEMP_MAX : (short_lo ? TEMP_ZERO : to_deg(syn[SY_REMOTE +: RAW_W]));
	end

	// results start at zero, written only by conversions
	always_ff @(posedge CLK_I)
	begin
		if (rst)
		begin
			loc_temp <= TEMP_RST;
			rem_temp <= TEMP_RST;
		end
		else if (conv_done)
		begin
			loc_temp <= loc_new;
			rem_temp <= rem_new;
		end
	end

	assign hits = {$signed(loc_new) >= $signed(loc_high), $signed(loc_new) <= $signed(loc_low),
		$signed(rem_new) >= $signed(rem_high), $signed(rem_new) <= $signed(rem_low)};

	// open detector taken at start only
	always_ff @(posedge CLK_I)
	begin
		if (rst)
			open_seen <= 1'b0;
		else if (conv_start)
			open_seen <= open_s;
	end

	// status flags cleared by a status read; a new hit wins over the clear
	assign flag_set = {conv_done ? hits : 4'h0, conv_start & open_s};
	assign flag_clr = (tx_done && !ara && (pointer == CMD_RD_STATUS)) ? 5'h1f : 5'h00;

	always_ff @(posedge CLK_I)
	begin
		if (rst)
			flags <= 5'h00;
		else
			flags <= (flags & ~flag_clr) | flag_set;
	end

	// one chance per conversion, masked by config
	assign alert_set = conv_done && !cfg[CFG_MASK_BIT - CFG_STOP_BIT] && ((|hits) || open_seen);
	// only a completed alert response read clears
	assign alert_clr = tx_done && ara;

	// latch kept when arbitration is lost
	always_ff @(posedge CLK_I)
	begin
		if (rst)
			alert_n <= 1'b1;
		else if (alert_set)
			alert_n <= 1'b0;
		else if (alert_clr)
			alert_n <= 1'b1;
	end

endmodule // tsr_top

// *** bench/tsr_checker.sv ***
// Purpose: port assertions for tsr_top
// Assumes: one clock domain, sync reset
// Notes: bus clock is seen raw, ahead of the synchroniser
`timescale 1ns/1ns
module tsr_checker
	import tsr_pkg::*;
#(
	parameter int CONV_CYCLES = CONV_CYCLES_DFLT
)
(
	// clock and reset
	input wire logic CLK_I,
	input wire logic RESET_I,
	// watched pins
	input wire logic SMB_CLK_I,
	input wire logic SMB_DATA_O,
	input wire logic SMB_DATA_OE_N_O,
	input wire logic ALERT_O,
	input wire logic ALERT_OE_N_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RESET_I);
	int gap;
	// cycles since alert last fell, saturating
	always_ff @(posedge CLK_I)
	begin
		if (RESET_I)
			gap <= CONV_CYCLES;
		else if ($fell(ALERT_OE_N_O))
			gap <= 0;
		else if (gap < CONV_CYCLES)
			gap <= gap + 1;
	end
	// five raw clock-high cycles outlast the sync delay
	sequence scl_high_run;
		SMB_CLK_I [*5];
	endsequence
	chk_data_zero: assert property (SMB_DATA_O == 1'b0)
		else $error("data pin driven high");
	chk_alert_zero: assert property (ALERT_O == 1'b0)
		else $error("alert pin driven high");
	chk_reset_quiet: assert property ($fell(RESET_I) |-> ALERT_OE_N_O && SMB_DATA_OE_N_O)
		else $error("pins driven after reset");
	chk_alert_clear: assert property ($rose(ALERT_OE_N_O) |-> SMB_CLK_I)
		else $error("alert released outside a bus bit");
	chk_alert_gap: assert property ($fell(ALERT_OE_N_O) |-> gap >= CONV_CYCLES - 2)
		else $error("alert raised twice in one conversion");
	chk_drive_start: assert property ($fell(SMB_DATA_OE_N_O) |-> !SMB_CLK_I)
		else $error("data drive began while clock high");
	chk_steady_high: assert property (scl_high_run |-> $stable(SMB_DATA_OE_N_O))
		else $error("data changed while clock high");
	chk_drive_hold: assert property ($fell(SMB_DATA_OE_N_O) |=> !SMB_DATA_OE_N_O [*8])
		else $error("driven bit too short");
endmodule // tsr_checker

bind tsr_top tsr_checker #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.CLK_I(CLK_I), .RESET_I(RESET_I),
	.SMB_CLK_I(SMB_CLK_I), .SMB_DATA_O(SMB_DATA_O), .SMB_DATA_OE_N_O(SMB_DATA_OE_N_O),
	.ALERT_O(ALERT_O), .ALERT_OE_N_O(ALERT_OE_N_O));

// *** bench/tsr_host.sv ***
// Purpose: serial bus host model for the sensor
// Assumes: 160 ns bus clock, data wire pulled up outside
// Notes: clock stands high between frames
`timescale 1ns/1ns
module tsr_host
(
	// bus wires
	output logic scl_o,
	output logic sda_low_o,
	input wire logic sda_i,
	// byte read back
	output logic got_o,
	output logic [7:0] got_byte_o
);
	localparam int Q = 40;
	// idle bus, nothing driven
	initial
	begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
		got_o = 1'b0;
		got_byte_o = 8'h00;
	end
	task automatic start();
		got_o = 1'b0;
		sda_low_o = 1'b0;
		#Q scl_o = 1'b1;
		#Q sda_low_o = 1'b1;
		#Q scl_o = 1'b0;
		#Q;
	endtask
	// stop ends the frame, clock left high
	task automatic stop();
		sda_low_o = 1'b1;
		#Q scl_o = 1'b1;
		#Q sda_low_o = 1'b0;
		#Q;
	endtask
	// data moves only while clock low, sampled mid high
	task automatic xfer(input logic v, output logic s);
		sda_low_o = !v;
		#Q scl_o = 1'b1;
		#Q s = sda_i;
		#Q scl_o = 1'b0;
		#Q;
	endtask
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			xfer(b[i], s);
		xfer(1'b1, s);
		ack = !s;
	endtask
	// read, last byte nacked; rival bits stand in for a competing replier
	task automatic rbyte(input logic last, input logic [7:0] rival, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--)
			xfer(rival[i], b[i]);
		xfer(last, s);
		got_byte_o = b;
		got_o = 1'b1;
	endtask
endmodule // tsr_host

// *** bench/testbench.sv ***
// Purpose: self-checking bench for tsr_top
// Assumes: short conversion counts, host model on the pins
// Notes: read bytes are checked against a queue
`timescale 1ns/1ns
module testbench;
	import tsr_pkg::*;
	localparam int CONV = 40;
	localparam logic [6:0] STRAP = 7'h2a;
	localparam logic [7:0] MK = 8'h5a; // value is arbitrary
	localparam logic [7:0] PT = 8'h3c; // value is arbitrary
	logic clk, rst, standby_n, open_d, sh_lo, sh_hi, scl, sda_low, got, d_o, d_oe_n, a_o, a_oe_n, rh, rl;
	logic [RAW_W-1:0] loc_raw, rem_raw;
	logic [7:0] got_byte;
	logic [7:0] q[$];
	// byte a competing device puts on the bus during reads, ff when none
	logic [7:0] rival;
	int bad_count, compares, cyc, seed, i, v, r;
	int tab [8] = '{520, 506, 101, 2, -2, -3, -220, -280};
	logic [7:0] rst_tab [9] = '{8'h00, 8'h00, 8'h00, 8'h0f, 8'h00, 8'h7f, 8'hc9, 8'h7f, 8'hc9};
	// pull-up on the shared data wire
	wire logic sda = !(sda_low || !d_oe_n);
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	tsr_top #(.CONV_CYCLES(CONV), .STEP_CYCLES(20), .MAKER_ID(MK), .PART_ID(PT)) DUT
	(
		.CLK_I(clk), .RESET_I(rst), .SMB_CLK_I(scl), .SMB_DATA_I(sda), .SMB_DATA_O(d_o),
		.SMB_DATA_OE_N_O(d_oe_n), .ALERT_O(a_o), .ALERT_OE_N_O(a_oe_n), .ADDR_STRAP_I(STRAP),
		.HARDWARE_STANDBY_PIN_N_I(standby_n), .LOCAL_RAW_I(loc_raw), .REMOTE_RAW_I(rem_raw),
		.REMOTE_DIODE_OPEN_I(open_d), .REMOTE_SHORT_LOW_I(sh_lo), .REMOTE_SHORT_SUPPLY_I(sh_hi)
	);
	tsr_host host (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda), .got_o(got), .got_byte_o(got_byte));
	// quarter degrees to clamped whole degrees
	function automatic int deg(input int qd);
		int d;
		d = (qd + 2) >>> 2;
		if (d > TEMP_HI_INT)
			d = TEMP_HI_INT;
		if (d < TEMP_LO_INT)
			d = TEMP_LO_INT;
		return d;
	endfunction
	task automatic finish_test();
		$display("counts: %0d compares, %0d mismatches", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic a, input logic b);
		compares++;
		if (a !== b)
		begin
			$display("MISMATCH %0t: pin or ack %b want %b", $time, a, b);
			bad_count++;
		end
	endtask
	task automatic adr(input logic [6:0] a, input logic rd_n, input logic ex);
		logic k;
		host.start();
		host.wbyte({a, rd_n}, k);
		chk(k, ex);
	endtask
	task automatic rcv(input logic [6:0] a, input logic ak, input logic [7:0] ex);
		logic [7:0] b;
		adr(a, 1'b1, ak);
		if (ak)
		begin
			q.push_back(ex);
			host.rbyte(1'b1, rival, b);
		end
		host.stop();
	endtask
	task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic two);
		logic k;
		adr(STRAP, 1'b0, 1'b1);
		host.wbyte(c, k);
		if (two)
			host.wbyte(d, k);
		host.stop();
	endtask
	task automatic rd(input logic [7:0] c, input logic [7:0] ex);
		logic k;
		adr(STRAP, 1'b0, 1'b1);
		host.wbyte(c, k);
		rcv(STRAP, 1'b1, ex);
	endtask
	// one-shot, then a full conversion time
	task automatic shot();
		wr(CMD_ONESHOT, 8'h00, 1'b0);
		repeat (CONV + 20) @(negedge clk);
	endtask
	// oldest note against each byte read
	always @(posedge got)
	begin
		compares++;
		if (q.size() == 0 || got_byte !== q[0])
		begin
			$display("MISMATCH %0t: read %h", $time, got_byte);
			bad_count++;
		end
		if (q.size() != 0)
			void'(q.pop_front());
	end
	// hang guard, well above the run length
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			bad_count++;
			finish_test();
		end
	end
	initial
	begin
		seed = 69;
		rival = 8'hff;
		rst = 1'b1;
		{standby_n, sh_lo, sh_hi, rh, rl} = 5'h00;
		open_d = 1'b1;
		loc_raw = '0;
		rem_raw = '0;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		repeat (8) @(negedge clk);
		rcv(STRAP, 1'b1, TEMP_RST);
		for (i = 0; i < 9; i++)
			rd(8'(i), rst_tab[i]);
		rd(CMD_RD_MAKER, MK);
		rd(CMD_RD_PART, PT);
		rd(8'h10, 8'h00);
		adr(7'h33, 1'b0, 1'b0);
		host.stop();
		rcv(ALERT_RESP_ADDR, 1'b0, 8'h00);
		$display("test reset done");
		wr(CMD_WR_CONFIG, 8'hc0, 1'b1);
		standby_n = 1'b1;
		open_d = 1'b0;
		rd(CMD_RD_CONFIG, 8'hcf);
		for (i = 0; i < 8; i++)
		begin
			v = tab[i];
			r = $random(seed) % 600;
			loc_raw = v[RAW_W-1:0];
			rem_raw = r[RAW_W-1:0];
			rh |= deg(r) >= 127;
			rl |= deg(r) <= -55;
			shot();
			rd(CMD_RD_LOCAL, 8'(deg(v)));
			rd(CMD_RD_REMOTE, 8'(deg(r)));
		end
		chk(a_oe_n, 1'b1);
		rd(CMD_RD_STATUS, {3'b011, rh, rl, 3'b000});
		loc_raw = '0;
		repeat (CONV + 20) @(negedge clk);
		rd(CMD_RD_LOCAL, 8'(deg(-280)));
		$display("test convert done");
		wr(CMD_WR_CONFIG, 8'h40, 1'b1);
		wr(CMD_WR_LHIGH, 8'h20, 1'b1);
		rd(CMD_RD_LHIGH, 8'h20);
		loc_raw = 12'h080;
		rem_raw = '0;
		shot();
		chk(a_oe_n, 1'b0);
		rd(CMD_RD_LOCAL, 8'h20);
		// auto conversions keep landing while the alert is pending
		wr(CMD_WR_RATE, 8'h07, 1'b1);
		rd(CMD_RD_RATE, 8'h07);
		wr(CMD_WR_CONFIG, 8'h00, 1'b1);
		loc_raw = 12'h0a0;
		repeat (CONV + 20) @(negedge clk);
		rd(CMD_RD_LOCAL, 8'h28);
		chk(a_oe_n, 1'b0);
		wr(CMD_WR_CONFIG, 8'h40, 1'b1);
		rcv(ALERT_RESP_ADDR, 1'b1, {STRAP, 1'b1});
		chk(a_oe_n, 1'b1);
		rcv(ALERT_RESP_ADDR, 1'b0, 8'h00);
		wr(CMD_SW_RESET, 8'h00, 1'b0);
		rd(CMD_RD_LHIGH, HIGH_LIM_RST);
		wr(CMD_WR_CONFIG, 8'h40, 1'b1);
		$display("test alert done");
		sh_lo = 1'b1;
		shot();
		rd(CMD_RD_REMOTE, TEMP_ZERO);
		chk(a_oe_n, 1'b1);
		sh_lo = 1'b0;
		sh_hi = 1'b1;
		shot();
		rd(CMD_RD_LOCAL, TEMP_MAX);
		rd(CMD_RD_REMOTE, TEMP_MAX);
		chk(a_oe_n, 1'b0);
		rcv(ALERT_RESP_ADDR, 1'b1, {STRAP, 1'b1});
		sh_hi = 1'b0;
		open_d = 1'b1;
		shot();
		chk(a_oe_n, 1'b0);
		rd(CMD_RD_STATUS, 8'h54);
		// a lower rival address wins the reply, our latch must hold
		rival = 8'h21;
		rcv(ALERT_RESP_ADDR, 1'b1, 8'h21);
		rival = 8'hff;
		chk(a_oe_n, 1'b0);
		rcv(ALERT_RESP_ADDR, 1'b1, {STRAP, 1'b1});
		$display("test fault done");
		finish_test();
	end
endmodule // testbench
